// ===== design/nvram_pkg.sv
// Purpose: shared constants and types for the serial nonvolatile memory slave
// Assumes: 50 MHz system clock, serial pins sampled through two flip-flops
// Notes:   status bits 6..2 and 7 model the nonvolatile cells; reset stands for power-up
//
// How it works
// - after identity opcode, 32 clocks shift identity out on falling SCK, SI ignored
// - identity order: maker byte, continuation byte, product byte one, product byte two
// - after the last identity bit, SO keeps that bit until chip select rises
// - sleep starts at the chip select rise ending an opcode-only sleep command
// - any SCK clock after the sleep opcode cancels the sleep request
// - asleep: SCK and SI ignored, SO released
// - chip select fall wakes; normal operation within the 400 us recovery time
// - guard bits: none, 18000h-1FFFFh, 10000h-1FFFFh, or whole array protected
// - guarded writes refused; latch low refuses all; lock with WP low refuses status
// - pause pin low with chip select low suspends the command without aborting
// - pause ends only when SCK returns to the level seen at pause entry
// - during pause SCK and SI ignored and SO released for reads
// - chip select rising during pause aborts the command in progress
// - pause abort before opcode recognition leaves the write-enable latch unchanged
// - commands start with an 8-bit opcode; identity 9Fh, sleep B9h
// - latch set by set command; cleared at power-up, clear command, write-ending rise
// - status: lock bit 7, guard bits 3..2, latch bit 1, bit 0 zero
// - chip select high: inputs ignored, SO released

package nvram_pkg;

	localparam int          ADDR_W           = 17;
	localparam int          BYTE_W           = 8;
	localparam int          OPCODE_BITS      = 8;
	localparam int          ID_BITS          = 32;
	localparam int          ADDR_BYTES       = 3;

	localparam logic [7:0]  OP_LATCH_SET     = 8'h06;
	localparam logic [7:0]  OP_LATCH_CLEAR   = 8'h04;
	localparam logic [7:0]  OP_STATUS_READ   = 8'h05;
	localparam logic [7:0]  OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0]  OP_ARRAY_READ    = 8'h03;
	localparam logic [7:0]  OP_ARRAY_WRITE   = 8'h02;
	localparam logic [7:0]  OP_IDENTITY_READ = 8'h9F;
	localparam logic [7:0]  OP_SLEEP         = 8'hB9;

	localparam int          SR_LOCK          = 7;
	localparam int          SR_GUARD_HI      = 3;
	localparam int          SR_GUARD_LO      = 2;
	localparam int          SR_LATCH         = 1;
	localparam logic [7:0]  STATUS_INIT      = 8'h00;

	localparam logic [ADDR_W-1:0] GUARD_QUARTER_BASE = 17'h18000;
	localparam logic [ADDR_W-1:0] GUARD_HALF_BASE    = 17'h10000;

	localparam int          WAKE_TIME_US     = 400;
	localparam int          CLK_FREQ_MHZ     = 50;
	localparam int          WAKE_CYCLES      = WAKE_TIME_US * CLK_FREQ_MHZ;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} pin_in_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] data;
	} array_write_t;

	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_ADDR,
		ST_WRITE_DATA,
		ST_STATUS_DATA,
		ST_SEND,
		ST_SLEEP_ARMED,
		ST_IGNORE
	} cmd_state_t;

	typedef enum logic [1:0] {
		SRC_ID,
		SRC_STATUS,
		SRC_ARRAY
	} out_src_t;

	typedef enum logic [1:0] {
		PWR_AWAKE,
		PWR_ASLEEP,
		PWR_WAKING
	} pwr_state_t;

endpackage

// ===== design/write_fifo.sv
// Purpose: small flip-flop FIFO carrying array writes to the memory side
// Assumes: single clock, depth a power of two
// Notes:   full and empty are registered flags
`timescale 1ns/1ps
`default_nettype none

module write_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("write_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;
	logic             full;
	logic             empty;

	wire              push       = i_in_valid & ~full;
	wire              pop        = i_out_ready & ~empty;
	wire [PTR_W:0]    next_count = count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

	assign o_in_ready  = ~full;
	assign o_out_valid = ~empty;
	assign o_out_data  = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			full   <= 1'b0;
			empty  <= 1'b1;
		end else begin
			wr_ptr <= wr_ptr + PTR_W'(push);
			rd_ptr <= rd_ptr + PTR_W'(pop);
			count  <= next_count;
			full   <= (next_count == (PTR_W+1)'(DEPTH));
			empty  <= (next_count == '0);
		end
	end

endmodule

`default_nettype wire

// ===== design/spi_nvram_slave.sv
// Purpose: serial slave command logic: identity, sleep, write guarding, pause
// Assumes: SPI mode 0 or 3; SCK at most about 1/6 of i_clk; i_rd_data follows o_rd_addr
// Notes:   array writes leave through a FIFO; reset models power-up
`timescale 1ns/1ps
`default_nettype none

module spi_nvram_slave
	import nvram_pkg::*;
#(
	parameter int         WAKE_CNT   = WAKE_CYCLES,
	parameter int         FIFO_DEPTH = 8,
	parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
	parameter logic [7:0] CONT_CODE  = 8'h7F,  // arbitrary value
	parameter logic [7:0] PROD_CODE0 = 8'h21,  // arbitrary value
	parameter logic [7:0] PROD_CODE1 = 8'h43   // arbitrary value
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	// serial pins
	input  wire logic              i_cs_n,
	input  wire logic              i_sck,
	input  wire logic              i_si,
	input  wire logic              i_hold_n,
	input  wire logic              i_wp_n,
	output logic                   o_so,
	output logic                   o_so_oe,
	// array read port
	output logic      [ADDR_W-1:0] o_rd_addr,
	input  wire logic [BYTE_W-1:0] i_rd_data,
	// array write stream
	output logic                   o_wr_valid,
	input  wire logic              i_wr_ready,
	output logic      [ADDR_W-1:0] o_wr_addr,
	output logic      [BYTE_W-1:0] o_wr_data,
	// status
	output logic      [7:0]        o_status,
	output logic                   o_asleep,
	output logic                   o_paused,
	output logic                   o_wr_overrun
);
	generate
		if (WAKE_CNT < 1 || FIFO_DEPTH < 2) begin : g_bad_param
			$error("spi_nvram_slave: WAKE_CNT and FIFO_DEPTH out of range");
		end
	endgenerate

	localparam int         WAKE_W      = $clog2(WAKE_CNT + 1);
	localparam logic [5:0] ID_LEN      = 6'(ID_BITS);
	localparam logic [2:0] LAST_BIT    = 3'(OPCODE_BITS - 1);
	localparam logic [1:0] LAST_ADDR_B = 2'(ADDR_BYTES - 1);

	function automatic logic is_guarded(input logic [1:0] guard, input logic [ADDR_W-1:0] a);
		unique case (guard)
			2'b00: is_guarded = 1'b0;
			2'b01: is_guarded = (a >= GUARD_QUARTER_BASE);
			2'b10: is_guarded = (a >= GUARD_HALF_BASE);
			2'b11: is_guarded = 1'b1;
		endcase
	endfunction

	// pin synchronisers and edge history
	pin_in_t    pin_meta;
	pin_in_t    pin_sync;
	pin_in_t    pin_prev;
	// power and pause
	pwr_state_t pwr;
	logic [WAKE_W-1:0] wake_cnt;
	logic       frame_live;
	logic       paused;
	logic       pause_level;
	// command engine
	cmd_state_t state;
	out_src_t   out_src;
	logic [7:0] shift_in;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic       addr_is_read;
	logic [ADDR_W-1:0] addr;
	logic [31:0] out_sr;
	logic [5:0] out_left;
	logic       send_started;
	logic       write_cmd_seen;
	logic       latch;
	logic [7:2] status_nv;
	logic       pend_valid;
	array_write_t pend;
	logic       fifo_in_ready;
	array_write_t fifo_out;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
			pin_sync <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
			pin_prev <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
		end else begin
			pin_meta <= '{cs_n: i_cs_n, sck: i_sck, si: i_si, hold_n: i_hold_n, wp_n: i_wp_n};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// decoded events
	wire        cs_fall      = pin_prev.cs_n & ~pin_sync.cs_n;
	wire        cs_rise      = ~pin_prev.cs_n & pin_sync.cs_n;
	wire        selected     = frame_live & ~pin_sync.cs_n;
	wire        live         = selected & ~paused;
	wire        rise         = live & pin_sync.sck & ~pin_prev.sck;
	wire        fall         = live & ~pin_sync.sck & pin_prev.sck;
	wire [7:0]  next_byte    = {shift_in[6:0], pin_sync.si};
	wire        byte_done    = rise & (bit_cnt == LAST_BIT);
	wire [1:0]  guard        = status_nv[SR_GUARD_HI:SR_GUARD_LO];
	wire [7:0]  status_word  = {status_nv, latch, 1'b0};
	wire        status_ok    = latch & ~(status_nv[SR_LOCK] & ~pin_sync.wp_n);
	wire        array_ok     = latch & ~is_guarded(guard, addr);
	wire [31:0] identity     = {MAKER_CODE, CONT_CODE, PROD_CODE0, PROD_CODE1};
	wire [7:0]  reload_byte  = (out_src == SRC_STATUS) ? status_word : i_rd_data;
	wire        reload       = (out_left == 6'd0) & (out_src != SRC_ID);
	wire        next_so_oe   = selected & ~paused & (state == ST_SEND) & send_started;

	// power state: sleep entry, wake on chip select fall, recovery count
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr      <= PWR_AWAKE;
			wake_cnt <= '0;
		end else begin
			unique case (pwr)
				PWR_AWAKE: begin
					if (cs_rise && frame_live && state == ST_SLEEP_ARMED && !paused) begin
						pwr <= PWR_ASLEEP;
					end
				end
				PWR_ASLEEP: begin
					if (cs_fall) begin
						pwr      <= PWR_WAKING;
						wake_cnt <= WAKE_W'(WAKE_CNT - 1);
					end
				end
				PWR_WAKING: begin
					if (wake_cnt == '0) begin
						pwr <= PWR_AWAKE;
					end else begin
						wake_cnt <= wake_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	// frame and pause tracking
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_live  <= 1'b0;
			paused      <= 1'b0;
			pause_level <= 1'b0;
		end else begin
			if (pin_sync.cs_n) begin
				frame_live <= 1'b0;
				paused     <= 1'b0;
			end else begin
				if (cs_fall && pwr == PWR_AWAKE) begin
					frame_live <= 1'b1;
				end
				if (!paused && !pin_sync.hold_n && frame_live) begin
					paused      <= 1'b1;
					pause_level <= pin_sync.sck;
				end else if (paused && pin_sync.hold_n && pin_sync.sck == pause_level) begin
					paused <= 1'b0;
				end
			end
		end
	end

	// command engine on sampled SCK edges
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state          <= ST_OPCODE;
			out_src        <= SRC_ID;
			shift_in       <= '0;
			bit_cnt        <= '0;
			byte_cnt       <= '0;
			addr_is_read   <= 1'b0;
			addr           <= '0;
			out_sr         <= '0;
			out_left       <= '0;
			send_started   <= 1'b0;
			write_cmd_seen <= 1'b0;
			latch          <= 1'b0;
			status_nv      <= STATUS_INIT[7:2];
		end else if (!selected) begin
			if (cs_rise && write_cmd_seen) begin
				latch <= 1'b0;
			end
			state          <= ST_OPCODE;
			bit_cnt        <= '0;
			byte_cnt       <= '0;
			send_started   <= 1'b0;
			write_cmd_seen <= 1'b0;
		end else begin
			if (rise) begin
				shift_in <= next_byte;
				bit_cnt  <= bit_cnt + 3'd1;
			end
			unique case (state)
				ST_OPCODE: begin
					if (byte_done) begin
						if (next_byte == OP_LATCH_SET) begin
							latch <= 1'b1;
							state <= ST_IGNORE;
						end else if (next_byte == OP_LATCH_CLEAR) begin
							latch <= 1'b0;
							state <= ST_IGNORE;
						end else if (next_byte == OP_STATUS_READ) begin
							out_src  <= SRC_STATUS;
							out_left <= '0;
							state    <= ST_SEND;
						end else if (next_byte == OP_STATUS_WRITE) begin
							write_cmd_seen <= 1'b1;
							state          <= ST_STATUS_DATA;
						end else if (next_byte == OP_ARRAY_READ || next_byte == OP_ARRAY_WRITE) begin
							addr_is_read   <= (next_byte == OP_ARRAY_READ);
							write_cmd_seen <= (next_byte == OP_ARRAY_WRITE);
							state          <= ST_ADDR;
						end else if (next_byte == OP_IDENTITY_READ) begin
							out_src  <= SRC_ID;
							out_sr   <= identity;
							out_left <= ID_LEN;
							state    <= ST_SEND;
						end else if (next_byte == OP_SLEEP) begin
							state <= ST_SLEEP_ARMED;
						end else begin
							state <= ST_IGNORE;
						end
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						addr     <= ADDR_W'({addr, next_byte});
						byte_cnt <= byte_cnt + 2'd1;
						if (byte_cnt == LAST_ADDR_B) begin
							out_src  <= SRC_ARRAY;
							out_left <= '0;
							state    <= addr_is_read ? ST_SEND : ST_WRITE_DATA;
						end
					end
				end
				ST_WRITE_DATA: begin
					if (byte_done) begin
						addr <= addr + 1'b1;
					end
				end
				ST_STATUS_DATA: begin
					if (byte_done) begin
						if (status_ok) begin
							status_nv <= next_byte[7:2];
						end
						state <= ST_IGNORE;
					end
				end
				ST_SEND: begin
					if (fall) begin
						send_started <= 1'b1;
						if (reload) begin
							// bit 7 leaves now; the register keeps the seven that follow
							out_sr   <= {reload_byte[BYTE_W-2:0], {(ID_BITS-BYTE_W+1){1'b0}}};
							out_left <= 6'(BYTE_W - 1);
							if (out_src == SRC_ARRAY) begin
								addr <= addr + 1'b1;
							end
						end else if (out_left != 6'd0) begin
							out_sr <= {out_sr[30:0], 1'b0};
						end
					end
				end
				ST_SLEEP_ARMED: begin
					if (rise) begin
						state <= ST_IGNORE;
					end
				end
				ST_IGNORE: begin
				end
			endcase
			if (fall && state == ST_SEND && !reload && out_left != 6'd0) begin
				out_left <= out_left - 6'd1;
			end
		end
	end

	// write hand-off into the FIFO; a byte arriving while one still waits on a full FIFO is lost
	wire take_byte = selected && state == ST_WRITE_DATA && byte_done && array_ok;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_valid   <= 1'b0;
			pend         <= '0;
			o_wr_overrun <= 1'b0;
		end else begin
			if (take_byte && (!pend_valid || fifo_in_ready)) begin
				pend_valid <= 1'b1;
				pend       <= '{addr: addr, data: next_byte};
			end else if (pend_valid && fifo_in_ready) begin
				pend_valid <= 1'b0;
			end
			if (take_byte && pend_valid && !fifo_in_ready) begin
				o_wr_overrun <= 1'b1;
			end
		end
	end

	write_fifo #(
		.WIDTH ($bits(array_write_t)),
		.DEPTH (FIFO_DEPTH)
	) u_write_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (pend_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (pend),
		.o_out_valid (o_wr_valid),
		.i_out_ready (i_wr_ready),
		.o_out_data  (fifo_out)
	);

	assign o_wr_addr = fifo_out.addr;
	assign o_wr_data = fifo_out.data;

	// serial output and status flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_so      <= 1'b0;
			o_so_oe   <= 1'b0;
			o_rd_addr <= '0;
			o_status  <= STATUS_INIT;
			o_asleep  <= 1'b0;
			o_paused  <= 1'b0;
		end else begin
			// once the identity is spent, SO keeps its last bit
			if (fall && state == ST_SEND && (reload || out_left != 6'd0)) begin
				o_so <= reload ? reload_byte[7] : out_sr[31];
			end
			o_so_oe   <= next_so_oe;
			o_rd_addr <= addr;
			o_status  <= status_word;
			o_asleep  <= (pwr != PWR_AWAKE);
			o_paused  <= paused;
		end
	end

endmodule

`default_nettype wire

// ===== bench/nvram_chk.sv
// Purpose: port checker for the serial memory slave
// Assumes: bound to spi_nvram_slave
// Notes:   serial pins reach the logic through a two-flop sync
`timescale 1ns/1ps
`default_nettype none
module nvram_chk
	import nvram_pkg::*;
#(
	parameter int WAKE_CNT = WAKE_CYCLES
) (
	// clock and reset
	input wire logic              i_clk,
	input wire logic              i_rst_n,
	// pins and outputs
	input wire logic              i_cs_n,
	input wire logic              i_hold_n,
	input wire logic              o_so_oe,
	input wire logic [7:0]        o_status,
	input wire logic              o_asleep,
	input wire logic              o_paused,
	input wire logic              o_wr_valid,
	input wire logic              i_wr_ready,
	input wire logic [ADDR_W-1:0] o_wr_addr,
	input wire logic [BYTE_W-1:0] o_wr_data
);
	logic [1:0] guard;
	logic       in_guard;
	logic       waking;
	int         wake_cnt;
	assign guard    = o_status[SR_GUARD_HI:SR_GUARD_LO];
	assign in_guard = guard == 2'h3 || (guard == 2'h2 && o_wr_addr >= GUARD_HALF_BASE) ||
		(guard == 2'h1 && o_wr_addr >= GUARD_QUARTER_BASE);
	// cycles spent asleep since the waking chip select fall
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			waking   <= 1'b0;
			wake_cnt <= 0;
		end else begin
			waking   <= o_asleep && (waking || !i_cs_n);
			wake_cnt <= (o_asleep && waking) ? wake_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	property p_desel_quiet;
		i_cs_n [*6] |-> !o_so_oe;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("SO driven while deselected");
	property p_sleep_quiet;
		o_asleep |-> !o_so_oe;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("SO driven while asleep");
	property p_sleep_entry;
		$rose(o_asleep) |-> i_cs_n && $past(i_cs_n, 2);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered while selected");
	property p_wake_bound;
		wake_cnt <= WAKE_CNT + 8;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake recovery too long");
	property p_pause_entry;
		(!i_cs_n && !i_hold_n && !o_asleep) [*6] |-> o_paused;
	endproperty
	a_pause_entry: assert property (p_pause_entry) else $error("pause not entered");
	property p_pause_cause;
		$rose(o_paused) |-> !$past(i_hold_n, 2) && !$past(i_cs_n, 2);
	endproperty
	a_pause_cause: assert property (p_pause_cause) else $error("pause without cause");
	property p_pause_quiet;
		o_paused [*2] |-> !o_so_oe;
	endproperty
	a_pause_quiet: assert property (p_pause_quiet) else $error("SO driven while paused");
	property p_latch_rise;
		$rose(o_status[SR_LATCH]) |-> !$past(i_cs_n, 4);
	endproperty
	a_latch_rise: assert property (p_latch_rise) else $error("latch set outside a frame");
	property p_bit0_zero;
		o_status[0] == 1'b0;
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 set");
	property p_wr_hold;
		o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write entry changed while stalled");
	property p_wr_guard;
		o_wr_valid |-> !in_guard;
	endproperty
	a_wr_guard: assert property (p_wr_guard) else $error("write to guarded address");
endmodule
`default_nettype wire

// ===== bench/spi_master_model.sv
// Purpose: serial master model driving the slave pins
// Assumes: mode 0, SCK period 8 bench clocks, pins change 1 ns after an edge
// Notes:   SCK rests low between frames; SO sampled late in the high phase
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	// bench clock
	input  wire logic       i_clk,
	// slave pins
	output var  logic       o_cs_n,
	output var  logic       o_sck,
	output var  logic       o_si,
	output var  logic       o_hold_n,
	input  wire logic       i_so_line,
	// last byte received
	output var  logic [7:0] o_rx
);
	event rx_done;
	initial begin
		o_cs_n   = 1'b1;
		o_sck    = 1'b0;
		o_si     = 1'b0;
		o_hold_n = 1'b1;
		o_rx     = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic start();
		o_cs_n = 1'b0;
		tick(4);
	endtask
	task automatic stop();
		tick(4);
		o_cs_n = 1'b1;
		tick(16);
	endtask
	// nb bits MSB first; pause_at is the bit held off by a pause, 8 for none
	task automatic xfer(input logic [7:0] tx, input int nb, input int pause_at, input logic note);
		for (int i = 7; i > 7 - nb; i--) begin
			o_si = tx[i];
			tick(4);
			if (i == pause_at) begin
				o_hold_n = 1'b0;
				tick(2);
				o_sck = 1'b1;
				o_si  = ~tx[i];
				tick(4);
				o_sck = 1'b0;
				tick(2);
				o_hold_n = 1'b1;
				o_si     = tx[i];
				tick(4);
			end
			o_sck = 1'b1;
			tick(4);
			o_rx[i] = i_so_line;
			o_sck   = 1'b0;
		end
		if (note) begin
			-> rx_done;
		end
	endtask
	// pause, then deselect while still paused
	task automatic abort_paused();
		o_hold_n = 1'b0;
		tick(6);
		o_cs_n = 1'b1;
		tick(6);
		o_hold_n = 1'b1;
		tick(16);
	endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Purpose: self-checking bench for the serial memory slave
// Assumes: 50 MHz clock, wake count shortened to WAKE cycles
// Notes:   expected bytes and writes queue up and are matched as they appear
`timescale 1ns/1ps
`default_nettype none
module tb;
	import nvram_pkg::*;
	localparam int          WAKE = 20;
	localparam logic [31:0] ID   = 32'hC37F2D97; // arbitrary value
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   wp_n = 1'b1;
	logic                   wr_ready = 1'b0;
	logic                   so_float = 1'b0;
	logic                   cs_n, sck, si, hold_n, so, so_oe, so_line;
	logic                   wr_valid, asleep, paused;
	logic [ADDR_W-1:0]      rd_addr, wr_addr;
	logic [7:0]             rd_data, wr_data, status, rx;
	int                     seed = 32'hD6ACF120;
	int                     err_total = 0;
	int                     num_checks = 0;
	int                     cycles = 0;
	logic [7:0]             exp_rx[$];
	array_write_t           exp_wr[$];
	spi_nvram_slave #(.WAKE_CNT(WAKE), .MAKER_CODE(ID[31:24]), .CONT_CODE(ID[23:16]),
		.PROD_CODE0(ID[15:8]), .PROD_CODE1(ID[7:0])) dut (.i_clk(clk), .i_rst_n(rst_n),
		.i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
		.o_so_oe(so_oe), .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
		.i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_status(status),
		.o_asleep(asleep), .o_paused(paused), .o_wr_overrun());
	spi_master_model m (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n),
		.i_so_line(so_line), .o_rx(rx));
	always #10 clk = ~clk;
	assign so_line = so_oe ? so : so_float;
	assign rd_data = rd_addr[7:0] ^ 8'hA5;
	// released SO shows the inverse of its last driven level; memory side stalls at random
	always @(posedge clk) begin
		#1;
		if (so_oe === 1'b1) begin
			so_float = ~so;
		end
		wr_ready = 1'($random(seed));
		cycles   = cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end
	always @(m.rx_done) begin
		chk("serial byte", exp_rx.pop_front(), rx);
	end
	always @(negedge clk) begin
		if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1) begin
			chk_wr(exp_wr.size() ? exp_wr.pop_front() : '1, {wr_addr, wr_data});
		end
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_wr(input array_write_t e, input array_write_t g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR write entry expected %h seen %h", e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	function automatic logic guarded(input logic [1:0] g, input logic [ADDR_W-1:0] a);
		return g == 2'h3 || (g == 2'h2 && a >= 17'h10000) || (g == 2'h1 && a >= 17'h18000);
	endfunction
	task automatic frame1(input logic [7:0] op);
		m.start();
		m.xfer(op, 8, 8, 1'b0);
		m.stop();
	endtask
	task automatic set_status(input logic [7:0] v, input logic en);
		if (en) begin
			frame1(OP_LATCH_SET);
		end
		m.start();
		m.xfer(OP_STATUS_WRITE, 8, 8, 1'b0);
		m.xfer(v, 8, 8, 1'b0);
		m.stop();
	endtask
	task automatic burst(input logic [1:0] g, input logic [ADDR_W-1:0] a, input logic en);
		logic [7:0] d;
		if (en) begin
			frame1(OP_LATCH_SET);
		end
		m.start();
		m.xfer(OP_ARRAY_WRITE, 8, 8, 1'b0);
		m.xfer({7'($random(seed)), a[16]}, 8, 8, 1'b0);
		m.xfer(a[15:8], 8, 8, 1'b0);
		m.xfer(a[7:0], 8, 8, 1'b0);
		for (int k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			if (en && !guarded(g, a + 17'(k))) begin
				exp_wr.push_back({a + 17'(k), d});
			end
			m.xfer(d, 8, 8, 1'b0);
		end
		m.stop();
		chk("latch after write", 1'b0, status[SR_LATCH]);
	endtask
	initial begin
		m.tick(12);
		rst_n = 1'b1;
		m.tick(12500);
		m.start();
		m.xfer(OP_IDENTITY_READ, 8, 8, 1'b0);
		for (int i = 3; i >= 0; i--) begin
			exp_rx.push_back(ID[i*8 +: 8]);
			m.xfer(8'($random(seed)), 8, 8, 1'b1);
		end
		exp_rx.push_back({8{ID[0]}});
		m.xfer(8'($random(seed)), 8, 8, 1'b1);
		m.stop();
		m.start();
		m.xfer(OP_SLEEP, 8, 8, 1'b0);
		m.xfer(8'h00, 1, 8, 1'b0);
		m.stop();
		chk("sleep after extra clock", 1'b0, asleep);
		frame1(OP_SLEEP);
		chk("asleep", 1'b1, asleep);
		frame1(OP_STATUS_READ);
		m.tick(WAKE + 20);
		chk("awake", 1'b0, asleep);
		frame1(OP_LATCH_SET);
		chk("latch set", 1'b1, status[SR_LATCH]);
		m.start();
		m.xfer(OP_STATUS_READ, 8, 3, 1'b0);
		exp_rx.push_back(8'h02);
		m.xfer(8'($random(seed)), 8, 4, 1'b1);
		m.stop();
		m.start();
		m.xfer(OP_LATCH_CLEAR, 4, 8, 1'b0);
		m.abort_paused();
		chk("latch after abort", 1'b1, status[SR_LATCH]);
		frame1(OP_LATCH_CLEAR);
		set_status(8'h0C, 1'b0);
		chk("status without latch", 8'h00, status);
		for (int g = 0; g < 4; g++) begin
			set_status({4'h0, 2'(g), 2'h3}, 1'b1);
			chk("guard status", {4'h0, 2'(g), 2'h0}, status);
			burst(2'(g), 17'h0FFFF, 1'b1);
			burst(2'(g), 17'h17FFF, 1'b1);
		end
		set_status(8'h80, 1'b1);
		burst(2'h0, 17'h00000, 1'b0);
		wp_n = 1'b0;
		set_status(8'h0C, 1'b1);
		chk("locked status", 8'h80, status);
		wp_n = 1'b1;
		set_status(8'h00, 1'b1);
		chk("unlocked status", 8'h00, status);
		m.tick(20);
		chk("results left", 0, exp_rx.size() + exp_wr.size());
		tally_and_finish();
	end
endmodule
bind spi_nvram_slave nvram_chk #(.WAKE_CNT(WAKE_CNT)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .o_so_oe(o_so_oe), .o_status(o_status),
	.o_asleep(o_asleep), .o_paused(o_paused), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
	.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
`default_nettype wire
